// >>> fcsp_cal_check.sv
// Purpose: Judges the outcome of a calibration command.
// Assumes: Sensor facts come from logic on the same clock.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module fcsp_cal_check
   import fcsp_pkg::*;
(
   // Command under test
   input  wire logic       isStored,
   input  wire logic       isHigh,
   // Sensor facts
   input  wire logic       sensorFound,
   input  wire logic       capEqual,
   input  wire logic [23:0] spanCounts,
   input  wire logic [23:0] minSpan,
   // Verdict
   output var  fcsp_word_t status
);
   // Picks the failure code for the calibration type, or success.
   always_comb
   begin
      status = ST_SUCCESS;
      if (isStored)
      begin
         if (!sensorFound)
            status = ST_NO_SENSOR;
         else if (!capEqual)
            status = ST_CAP_MISMAT;
      end
      else if (isHigh && spanCounts < minSpan)
         status = ST_SPAN_FAIL;
   end
endmodule
`default_nettype wire

// >>> fcsp_host_model.sv
// Purpose: Host controller writing the output table of the filler channel.
// Assumes: Commands are one-cycle strobes taken at the rising edge.
// Notes:   Released words are inverted so stale values are never trusted.
`timescale 1ns/1ps
`default_nettype none
module fcsp_host_model
   import fcsp_pkg::*;
(
   // Clock and reply
   input  wire logic                 core_clk,
   input  wire logic                 replyValid,
   // Output table
   output var  logic                 cmdStrobe,
   output var  fcsp_pkg::fcsp_word_t cmdWord,
   output var  fcsp_pkg::fcsp_word_t parNum,
   output var  fcsp_pkg::fcsp_word_t parVal
);
   // Idle table at time zero.
   initial
   begin
      cmdStrobe = 1'b0;
      cmdWord = '0;
      parNum = '0;
      parVal = '0;
   end
   // One command, then a bounded wait for the reply pulse.
   task automatic send(input fcsp_word_t c, input fcsp_word_t p, input fcsp_word_t v);
      int n;
      n = 0;
      @(posedge core_clk);
      cmdStrobe <= 1'b1;
      cmdWord <= c;
      parNum <= p;
      parVal <= v;
      @(posedge core_clk);
      cmdStrobe <= 1'b0;
      cmdWord <= ~c;
      parNum <= ~p;
      parVal <= ~v;
      do
      begin
         @(negedge core_clk);
         n++;
      end
      while (replyValid !== 1'b1 && n < 4);
   endtask
endmodule
`default_nettype wire

// >>> fcsp_nv_commit.sv
// Purpose: Drives one commit of a parameter or calibration to non-volatile storage.
// Assumes: Storage accepts a write strobe and completes it within the fixed NV_CYC-cycle busy window.
// Notes:   A request while busy is dropped; the command logic never issues one then.
`timescale 1ns/1ps
`default_nettype none
module fcsp_nv_commit
   import fcsp_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   // Request side
   fcsp_nv_if.snk          nv,
   // Storage side
   output var  logic       wrStb,
   output var  logic       wrCal,
   output var  logic [PAR_IDX_W-1:0] wrIdx,
   output var  logic [PAR_VAL_W-1:0] wrVal
);
   logic [2:0] cnt_r;

   // ------------
   // Commit sequencing
   // ------------
   // Latches the request and holds busy for a fixed commit window.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         cnt_r <= 3'h0;
         wrStb <= 1'b0;
         wrCal <= 1'b0;
         wrIdx <= '0;
         wrVal <= '0;
      end
      else if (nv.req && cnt_r == 3'h0)
      begin
         cnt_r <= 3'(NV_CYC);
         wrStb <= 1'b1;
         wrCal <= nv.isCal;
         wrIdx <= nv.idx;
         wrVal <= nv.val;
      end
      else
      begin
         wrStb <= 1'b0;
         if (cnt_r != 3'h0)
            cnt_r <= cnt_r - 3'h1;
      end
   end

   assign nv.busy = (cnt_r != 3'h0);
endmodule
`default_nettype wire

// >>> fcsp_nv_if.sv
// Purpose: Carries commit requests from the command logic to the storage sequencer.
// Assumes: One clock domain.
// Notes:   Request is a one-cycle pulse; busy stays high while a commit runs.
`timescale 1ns/1ps
`default_nettype none
interface fcsp_nv_if;
   import fcsp_pkg::*;
   logic                 req;
   logic                 isCal;
   logic [PAR_IDX_W-1:0] idx;
   logic [PAR_VAL_W-1:0] val;
   logic                 busy;
   modport src (output req, output isCal, output idx, output val, input busy);
   modport snk (input req, input isCal, input idx, input val, output busy);
endinterface
`default_nettype wire

// >>> fcsp_pkg.sv
// Purpose: Shared constants for the filler command status and parameter store.
// Assumes: Command, parameter and status words are signed integers (value x1.0).
// Notes:   Status codes are the negative whole numbers of the float codes.
package fcsp_pkg;
   // ------------
   // Word widths
   // ------------
   localparam int WORD_W = 32;
   typedef logic signed [WORD_W-1:0] fcsp_word_t;

   // ------------
   // Command codes
   // ------------
   localparam fcsp_word_t CMD_NONE       = 32'sh0000_0000;
   localparam fcsp_word_t CMD_SAVE_ALL   = 32'sh0000_0011;
   localparam fcsp_word_t CMD_REFILL     = 32'sh0000_0012;
   localparam fcsp_word_t CMD_START_FILL = 32'sh0000_0001;
   localparam fcsp_word_t CMD_TARE       = 32'sh0000_0062;
   localparam fcsp_word_t CMD_ZERO       = 32'sh0000_0063;
   localparam fcsp_word_t CMD_CAL_LOW    = 32'sh0000_0064;
   localparam fcsp_word_t CMD_CAL_HIGH   = 32'sh0000_0065;
   localparam fcsp_word_t CMD_CAL_STORED = 32'sh0000_0066;
   localparam fcsp_word_t CMD_PARAM_WR   = 32'sh0000_0067;
   localparam fcsp_word_t CMD_PARAM_RD   = 32'sh0000_0069;
   localparam fcsp_word_t CMD_DEFAULTS   = 32'sh0000_0094;

   // ------------
   // Status codes
   // ------------
   localparam fcsp_word_t ST_SUCCESS     = 32'sh0000_0000;
   localparam fcsp_word_t ST_BAD_STATE   = -32'sh0000_0001;
   localparam fcsp_word_t ST_RANGE_FAIL  = -32'sh0000_0004;
   localparam fcsp_word_t ST_UNKNOWN_CMD = -32'sh0000_0005;
   localparam fcsp_word_t ST_NO_SENSOR   = -32'sh0000_0006;
   localparam fcsp_word_t ST_CAP_MISMAT  = -32'sh0000_0007;
   localparam fcsp_word_t ST_SPAN_FAIL   = -32'sh0000_0008;
   localparam fcsp_word_t ST_UNKNOWN_PAR = -32'sh0000_0009;

   // ------------
   // Parameter numbers, store size and defaults
   // ------------
   localparam int PAR_N       = 10;
   localparam int PAR_IDX_W   = 4;
   localparam int PAR_VAL_W   = 8;
   localparam logic [PAR_IDX_W-1:0] P_ENABLE  = 4'h1;
   localparam logic [PAR_IDX_W-1:0] P_UNITS   = 4'h2;
   localparam logic [PAR_IDX_W-1:0] P_AVG     = 4'h3;
   localparam logic [PAR_IDX_W-1:0] P_SUPP    = 4'h4;
   localparam logic [PAR_IDX_W-1:0] P_ZTRACK  = 4'h5;
   localparam logic [PAR_IDX_W-1:0] P_SOURCE  = 4'h6;
   localparam logic [PAR_IDX_W-1:0] P_REFILL  = 4'h7;
   localparam logic [PAR_IDX_W-1:0] P_RATE    = 4'h8;
   localparam logic [PAR_IDX_W-1:0] P_MATL    = 4'h9;
   localparam logic [PAR_IDX_W-1:0] P_FRFILT  = 4'ha;
   // Defaults and largest legal values, indexed by parameter number.
   localparam logic [PAR_VAL_W-1:0] DEF_VAL [1:PAR_N] =
      '{8'h01, 8'h03, 8'h0a, 8'h03, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01};
   localparam logic [PAR_VAL_W-1:0] MAX_VAL [1:PAR_N] =
      '{8'h01, 8'h05, 8'hff, 8'h05, 8'h01, 8'h02, 8'h01, 8'h01, 8'h01, 8'h03};
   localparam logic [PAR_VAL_W-1:0] MIN_AVG = 8'h01;

   // ------------
   // Non-volatile commit handshake
   // ------------
   localparam int NV_CYC = 4;
endpackage

// >>> fcsp_top.sv
// Purpose: Command interpreter and parameter store of a weighing filler channel.
// Assumes: Host words arrive from logic on core_clk; cmdStrobe marks a new command.
// Notes:   Summary of operation follows.
// Summary of operation
// - Every command returns its echo and a status word.
// - Successful command reports status zero.
// - Fill start while refilling, or refill while filling, gets status -1.
// - Stored-data calibration: no sensors gives -6, unequal capacities gives -7.
// - High calibration step with too small count span gives -8.
// - Parameter write takes number from word 1, value from word 2.
// - Parameter changed by command is committed to storage unless another write comes before its commit starts.
// - Successful calibration is stored automatically.
// - Parameter 1 enables the channel, default on.
// - Parameter 2 selects weight unit 0..5, default kilograms.
// - Parameter 3 averages 1..255 samples, default 10.
// - Parameter 5 enables zero tracking, default off.
// - Parameter 6 selects weight source 0..2, default 2.
// - Auto refill starts when next dispense would fall below start weight.
// - Auto refill ends when weight reaches stop weight.
// - Auto refill only in single relay mode.
// - Parameter 7 zero means manual refill by host command.
// - Parameter 8 selects 145Hz or 95Hz reading rate, default 145Hz.
// - Parameter 9 selects material compensation, default liquids.
// - Parameter 10 selects flow-rate input 0..3, default adaptive.
// - Parameter read returns value in input word 2.
`timescale 1ns/1ps
`default_nettype none
module fcsp_top
   import fcsp_pkg::*;
(
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 sys_rst,
   // Host output table
   input  wire logic                 cmdStrobe,
   input  wire fcsp_pkg::fcsp_word_t cmdWord,
   input  wire fcsp_pkg::fcsp_word_t parNum,
   input  wire fcsp_pkg::fcsp_word_t parVal,
   // Host input table
   output var  fcsp_pkg::fcsp_word_t echoWord,
   output var  fcsp_pkg::fcsp_word_t statusWord,
   output var  fcsp_pkg::fcsp_word_t readWord,
   output var  logic                 replyValid,
   // Weighing process facts
   input  wire logic                 singleRelay,
   input  wire logic [23:0]          weightNow,
   input  wire logic [23:0]          doseSize,
   input  wire logic [23:0]          startRefillWt,
   input  wire logic [23:0]          stopRefillWt,
   input  wire logic                 fillDone,
   // Calibration facts
   input  wire logic                 sensorFound,
   input  wire logic                 capEqual,
   input  wire logic [23:0]          spanCounts,
   input  wire logic [23:0]          minSpan,
   // Process control outputs
   output var  logic                 filling,
   output var  logic                 refilling,
   output var  logic                 calDone,
   // Parameter outputs
   output var  logic                 chanEnable,
   output var  logic [2:0]           weightUnit,
   output var  logic [7:0]           sampleAverageDepth,
   output var  logic [2:0]           suppressSel,
   output var  logic                 zeroTrackEn,
   output var  logic [1:0]           weightSource,
   output var  logic                 autoRefillEn,
   output var  logic                 slowRate,
   output var  logic                 coarseMaterial,
   output var  logic [1:0]           flowRateSel,
   // Non-volatile storage port
   output var  logic                 nvWrStb,
   output var  logic                 nvWrCal,
   output var  logic [PAR_IDX_W-1:0] nvWrIdx,
   output var  logic [PAR_VAL_W-1:0] nvWrVal
);
   // ------------
   // Storage
   // ------------
   logic [PAR_VAL_W-1:0] par_r [1:PAR_N];
   fcsp_nv_if            nv ();
   fcsp_word_t           calStatus;
   logic                 isStoredCal;
   logic                 isHighCal;
   logic                 parKnown;
   logic                 valOk;
   logic [PAR_IDX_W-1:0] pIdx;
   logic [PAR_VAL_W-1:0] pVal;
   fcsp_word_t           status_nxt;
   logic                 doWrite;
   logic                 doDefaults;
   logic                 doCal;
   logic                 saveAll_r;
   logic [PAR_IDX_W-1:0] saveIdx_r;
   logic                 nvReq;
   logic                 nvCal;
   logic [PAR_IDX_W-1:0] nvIdx;
   logic [PAR_VAL_W-1:0] nvVal;
   logic                 pendCal_r;
   logic                 pendPar_r;
   logic [PAR_IDX_W-1:0] pendIdx_r;
   logic [24:0]          refillAt;

   // Flags the two calibration commands that can fail on sensor facts.
   assign isStoredCal = (cmdWord == CMD_CAL_STORED);
   assign isHighCal   = (cmdWord == CMD_CAL_HIGH);

   // One bit wider so that a high start level plus a dose cannot wrap.
   assign refillAt = 25'(startRefillWt) + 25'(doseSize);

   // ------------
   // Calibration verdict
   // ------------
   // Judges the sensor facts for the calibration command now presented.
   fcsp_cal_check u_cal (
      .isStored    (isStoredCal),
      .isHigh      (isHighCal),
      .sensorFound (sensorFound),
      .capEqual    (capEqual),
      .spanCounts  (spanCounts),
      .minSpan     (minSpan),
      .status      (calStatus)
   );

   // ------------
   // Parameter number and value checks
   // ------------
   // Word 1 names the parameter and word 2 carries the value.
   always_comb
   begin
      pIdx     = parNum[PAR_IDX_W-1:0];
      pVal     = parVal[PAR_VAL_W-1:0];
      parKnown = (parNum >= 32'sh1) && (parNum <= 32'(PAR_N));
      valOk    = 1'b0;
      if (parKnown && parVal >= 32'sh0 && parVal <= 32'(MAX_VAL[pIdx]))
         valOk = (pIdx != P_AVG) || (pVal >= MIN_AVG);
   end

   // ------------
   // Command decode
   // ------------
   // Chooses the status and the store action for the current command.
   always_comb
   begin
      status_nxt = ST_SUCCESS;
      doWrite    = 1'b0;
      doDefaults = 1'b0;
      doCal      = 1'b0;
      if (cmdWord == CMD_PARAM_WR)
      begin
         if (!parKnown)
            status_nxt = ST_UNKNOWN_PAR;
         else if (!valOk)
            status_nxt = ST_RANGE_FAIL;
         else
            doWrite = 1'b1;
      end
      else if (cmdWord == CMD_PARAM_RD)
      begin
         if (!parKnown)
            status_nxt = ST_UNKNOWN_PAR;
      end
      else if (cmdWord == CMD_START_FILL)
      begin
         if (refilling)
            status_nxt = ST_BAD_STATE;
      end
      else if (cmdWord == CMD_REFILL)
      begin
         if (filling)
            status_nxt = ST_BAD_STATE;
      end
      else if (cmdWord == CMD_CAL_LOW || isHighCal || isStoredCal)
      begin
         status_nxt = calStatus;
         doCal      = (calStatus == ST_SUCCESS);
      end
      else if (cmdWord == CMD_DEFAULTS)
         doDefaults = 1'b1;
      else if (cmdWord == CMD_SAVE_ALL || cmdWord == CMD_TARE || cmdWord == CMD_ZERO
               || cmdWord == CMD_NONE)
         status_nxt = ST_SUCCESS;
      else
         status_nxt = ST_UNKNOWN_CMD;
   end

   // ------------
   // Reply words
   // ------------
   // Echo and status are loaded together for every command.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         echoWord   <= '0;
         statusWord <= ST_SUCCESS;
         readWord   <= '0;
         replyValid <= 1'b0;
      end
      else
      begin
         replyValid <= cmdStrobe;
         if (cmdStrobe)
         begin
            echoWord   <= cmdWord;
            statusWord <= status_nxt;
            if (cmdWord == CMD_PARAM_RD && parKnown)
               readWord <= {24'h0, par_r[pIdx]};
         end
      end
   end

   // ------------
   // Parameter store
   // ------------
   // Rejected writes leave the store untouched.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || (cmdStrobe && doDefaults))
      begin
         for (int i = 1; i <= PAR_N; i++)
            par_r[i] <= DEF_VAL[i];
      end
      else if (cmdStrobe && doWrite)
         par_r[pIdx] <= pVal;
   end

   // ------------
   // Parameter outputs
   // ------------
   // Each field is registered from the store so outputs come from flops.
   always_ff @(posedge core_clk)
   begin
      chanEnable         <= par_r[P_ENABLE][0];
      weightUnit         <= par_r[P_UNITS][2:0];
      sampleAverageDepth <= par_r[P_AVG];
      suppressSel        <= par_r[P_SUPP][2:0];
      zeroTrackEn        <= par_r[P_ZTRACK][0];
      weightSource       <= par_r[P_SOURCE][1:0];
      autoRefillEn       <= par_r[P_REFILL][0] && singleRelay;
      slowRate           <= par_r[P_RATE][0];
      coarseMaterial     <= par_r[P_MATL][0];
      flowRateSel        <= par_r[P_FRFILT][1:0];
   end

   // ------------
   // Fill and refill state
   // ------------
   // Fill runs until fillDone; refill is manual or automatic.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         filling   <= 1'b0;
         refilling <= 1'b0;
      end
      else
      begin
         if (cmdStrobe && cmdWord == CMD_START_FILL && !refilling)
            filling <= 1'b1;
         else if (fillDone)
            filling <= 1'b0;
         if (cmdStrobe && cmdWord == CMD_REFILL && !filling)
            refilling <= 1'b1;
         else if (!filling && !refilling && autoRefillEn
                  && 25'(weightNow) < refillAt)
            refilling <= 1'b1;
         else if (refilling && weightNow >= stopRefillWt)
            refilling <= 1'b0;
      end
   end

   // ------------
   // Commit scheduling
   // ------------
   // Changes wait here while a previous commit is still in flight.
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         pendCal_r <= 1'b0;
         pendPar_r <= 1'b0;
         pendIdx_r <= '0;
         saveAll_r <= 1'b0;
         saveIdx_r <= '0;
         calDone   <= 1'b0;
      end
      else
      begin
         calDone <= cmdStrobe && doCal;
         if (cmdStrobe && doCal)
            pendCal_r <= 1'b1;
         else if (nvReq && nvCal)
            pendCal_r <= 1'b0;
         if (cmdStrobe && doWrite)
         begin
            pendPar_r <= 1'b1;
            pendIdx_r <= pIdx;
         end
         else if (nvReq && !nvCal && !saveAll_r)
            pendPar_r <= 1'b0;
         if (cmdStrobe && (doDefaults || cmdWord == CMD_SAVE_ALL))
         begin
            saveAll_r <= 1'b1;
            saveIdx_r <= 4'h1;
         end
         else if (nvReq && !nvCal && saveAll_r)
         begin
            if (saveIdx_r == 4'(PAR_N))
               saveAll_r <= 1'b0;
            saveIdx_r <= saveIdx_r + 4'h1;
         end
      end
   end

   // Picks the next commit: calibration first, then bulk save, then single.
   always_comb
   begin
      nvReq = !nv.busy && (pendCal_r || saveAll_r || pendPar_r);
      nvCal = pendCal_r;
      nvIdx = saveAll_r ? saveIdx_r : pendIdx_r;
      nvVal = pendCal_r ? '0 : par_r[nvIdx];
   end

   // Hands the chosen commit to the storage sequencer.
   assign nv.req   = nvReq;
   assign nv.isCal = nvCal;
   assign nv.idx   = nvIdx;
   assign nv.val   = nvVal;

   // Runs one commit at a time and reports busy meanwhile.
   fcsp_nv_commit u_nv (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .nv       (nv),
      .wrStb    (nvWrStb),
      .wrCal    (nvWrCal),
      .wrIdx    (nvWrIdx),
      .wrVal    (nvWrVal)
   );
endmodule
`default_nettype wire

// >>> fcsp_top_monitor.sv
// Purpose: Port checker for the filler command and parameter store.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every fcsp_top instance.
`timescale 1ns/1ps
`default_nettype none
module fcsp_top_monitor
   import fcsp_pkg::*;
(
   // Clock and reset
   input wire logic                 core_clk,
   input wire logic                 sys_rst,
   // Host tables
   input wire logic                 cmdStrobe,
   input wire fcsp_pkg::fcsp_word_t cmdWord,
   input wire fcsp_pkg::fcsp_word_t parNum,
   input wire fcsp_pkg::fcsp_word_t parVal,
   input wire fcsp_pkg::fcsp_word_t echoWord,
   input wire fcsp_pkg::fcsp_word_t statusWord,
   input wire logic                 replyValid,
   // Process and calibration
   input wire logic                 singleRelay,
   input wire logic                 sensorFound,
   input wire logic                 capEqual,
   input wire logic [23:0]          spanCounts,
   input wire logic [23:0]          minSpan,
   input wire logic                 filling,
   input wire logic                 refilling,
   input wire logic                 autoRefillEn,
   input wire logic                 nvWrStb,
   input wire logic                 nvWrCal
);
   logic known;
   logic wr;
   logic cs;
   logic idle;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Decodes of the command under way.
   assign known = cmdWord inside {CMD_NONE, CMD_START_FILL, CMD_SAVE_ALL, CMD_REFILL,
      CMD_TARE, CMD_ZERO, CMD_CAL_LOW, CMD_CAL_HIGH, CMD_CAL_STORED, CMD_PARAM_WR,
      CMD_PARAM_RD, CMD_DEFAULTS};
   assign wr = cmdStrobe && cmdWord == CMD_PARAM_WR;
   assign cs = cmdStrobe && cmdWord == CMD_CAL_STORED;
   assign idle = !filling && !refilling;
   AST_REPLY: assert property (cmdStrobe |=> replyValid)
      else $error("no reply after command");
   AST_ECHO: assert property (cmdStrobe |=> echoWord == $past(cmdWord))
      else $error("echo differs from command");
   AST_UNKCMD: assert property (cmdStrobe && !known |=> statusWord == ST_UNKNOWN_CMD)
      else $error("bad command not refused");
   AST_UNKPAR: assert property (wr && !(parNum inside {[1:10]})
      |=> statusWord == ST_UNKNOWN_PAR) else $error("bad parameter not refused");
   AST_WROK: assert property (wr && idle && parNum inside {[1:10]}
      && parVal <= MAX_VAL[parNum[3:0]] && !(parNum == 3 && parVal == 0)
      |=> statusWord == ST_SUCCESS) else $error("legal write not accepted");
   AST_NOSENS: assert property (cs && !sensorFound |=> statusWord == ST_NO_SENSOR)
      else $error("missing sensors not reported");
   AST_CAPEQ: assert property (cs && sensorFound && !capEqual
      |=> statusWord == ST_CAP_MISMAT) else $error("capacity mismatch not reported");
   AST_SPAN: assert property (cmdStrobe && cmdWord == CMD_CAL_HIGH
      && spanCounts < minSpan |=> statusWord == ST_SPAN_FAIL) else $error("span not refused");
   AST_CALNV: assert property (cs && sensorFound && capEqual && idle
      |=> statusWord == ST_SUCCESS ##[1:12] nvWrStb && nvWrCal) else $error("cal not stored");
   AST_FILLBAD: assert property (cmdStrobe && cmdWord == CMD_START_FILL && refilling
      |=> statusWord == ST_BAD_STATE) else $error("fill during refill accepted");
   AST_REFBAD: assert property (cmdStrobe && cmdWord == CMD_REFILL && filling
      |=> statusWord == ST_BAD_STATE) else $error("refill during fill accepted");
   AST_MUTEX: assert property (!(filling && refilling))
      else $error("fill and refill together");
   AST_RELAY: assert property (!singleRelay ##1 !singleRelay |=> !autoRefillEn)
      else $error("auto refill without single relay");
   // Main scenarios reached.
   cover property (wr ##1 statusWord == ST_SUCCESS);
   cover property (cmdStrobe && refilling ##1 statusWord == ST_BAD_STATE);
   cover property (nvWrStb && nvWrCal);
endmodule
bind fcsp_top fcsp_top_monitor u_mon (.core_clk, .sys_rst, .cmdStrobe, .cmdWord, .parNum,
   .parVal, .echoWord, .statusWord, .replyValid, .singleRelay, .sensorFound, .capEqual,
   .spanCounts, .minSpan, .filling, .refilling, .autoRefillEn, .nvWrStb, .nvWrCal);
`default_nettype wire

// >>> fcsp_top_tb_top.sv
// Purpose: Self-checking bench for the filler command and parameter store.
// Assumes: Host model issues commands; replies are read at the falling edge.
// Notes:   Weighing and calibration facts are driven here directly.
`timescale 1ns/1ps
`default_nettype none
module fcsp_top_tb_top;
   import fcsp_pkg::*;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        singleRelay = 1'b0;
   logic        fillDone = 1'b0;
   logic        sensorFound = 1'b1;
   logic        capEqual = 1'b1;
   logic [23:0] weightNow = 24'h100000, doseSize = 24'h000010, startRefillWt = 24'h001000;
   logic [23:0] stopRefillWt = 24'hffffff, spanCounts = 24'h000064, minSpan = 24'h00000a;
   logic        cmdStrobe, replyValid, filling, refilling, calDone, nvWrStb, nvWrCal, nvCal;
   logic        chanEnable, zeroTrackEn, autoRefillEn, slowRate, coarseMaterial;
   logic [1:0]  weightSource, flowRateSel;
   logic [2:0]  weightUnit, suppressSel;
   logic [3:0]  nvWrIdx, nvIdx;
   logic [7:0]  sampleAverageDepth, nvWrVal, nvVal;
   fcsp_word_t  cmdWord, parNum, parVal, echoWord, statusWord, readWord;
   fcsp_word_t  okCmd [4] = '{CMD_NONE, CMD_SAVE_ALL, CMD_TARE, CMD_ZERO};
   int          errCount = 0;
   int          samplesChecked = 0;
   int          cyc = 0;
   fcsp_top dut (.core_clk, .sys_rst, .cmdStrobe, .cmdWord, .parNum, .parVal, .echoWord,
      .statusWord, .readWord, .replyValid, .singleRelay, .weightNow, .doseSize,
      .startRefillWt, .stopRefillWt, .fillDone, .sensorFound, .capEqual, .spanCounts,
      .minSpan, .filling, .refilling, .calDone, .chanEnable, .weightUnit,
      .sampleAverageDepth, .suppressSel, .zeroTrackEn, .weightSource, .autoRefillEn,
      .slowRate, .coarseMaterial, .flowRateSel, .nvWrStb, .nvWrCal, .nvWrIdx, .nvWrVal);
   fcsp_host_model host (.core_clk, .replyValid, .cmdStrobe, .cmdWord, .parNum, .parVal);
   // Clock of 100 ns period.
   always #50 core_clk = ~core_clk;
   // Keeps the last commit seen on the storage port.
   always @(posedge core_clk)
   begin
      if (nvWrStb === 1'b1)
      begin
         nvIdx <= nvWrIdx;
         nvVal <= nvWrVal;
         nvCal <= nvWrCal;
      end
   end
   // Cuts a hung run short.
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         errCount++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", errCount, samplesChecked);
      if (errCount == 0 && samplesChecked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samplesChecked++;
      if (g !== e)
      begin
         errCount++;
         $display("[ERR] %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic cmd(input fcsp_word_t c, input fcsp_word_t p, input fcsp_word_t v,
                      input fcsp_word_t s);
      host.send(c, p, v);
      chk("replyValid", 1, replyValid);
      chk("echoWord", c, echoWord);
      chk("statusWord", s, statusWord);
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Main sequence of commands and expected answers.
   initial
   begin
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      wt(2);
      chk("chanEnable", 1, chanEnable);
      chk("weightUnit", 3, weightUnit);
      chk("avgDepth", 10, sampleAverageDepth);
      chk("zeroTrackEn", 0, zeroTrackEn);
      chk("weightSource", 2, weightSource);
      chk("autoRefillEn", 0, autoRefillEn);
      chk("slowRate", 0, slowRate);
      chk("coarseMaterial", 0, coarseMaterial);
      chk("flowRateSel", 1, flowRateSel);
      for (int i = 1; i <= PAR_N; i++)
      begin
         cmd(CMD_PARAM_WR, i, MAX_VAL[i], ST_SUCCESS);
         cmd(CMD_PARAM_RD, i, 0, ST_SUCCESS);
         chk("readWord", MAX_VAL[i], readWord);
      end
      wt(8);
      chk("nvIdx", 10, nvIdx);
      chk("nvVal", 3, nvVal);
      chk("weightUnit", 5, weightUnit);
      chk("avgDepth", 255, sampleAverageDepth);
      chk("autoRefillEn", 0, autoRefillEn);
      @(posedge core_clk) singleRelay <= 1'b1;
      wt(3);
      chk("autoRefillEn", 1, autoRefillEn);
      @(posedge core_clk) weightNow <= 24'h000100;
      wt(2);
      chk("refilling", 1, refilling);
      @(posedge core_clk) weightNow <= 24'hffffff;
      wt(2);
      chk("refilling", 0, refilling);
      @(posedge core_clk) weightNow <= 24'h100000;
      cmd(CMD_PARAM_WR, 3, 0, ST_RANGE_FAIL);
      cmd(CMD_PARAM_WR, 11, 1, ST_UNKNOWN_PAR);
      cmd(CMD_PARAM_WR, 2, 6, ST_RANGE_FAIL);
      cmd(32'sh0000_0032, 0, 0, ST_UNKNOWN_CMD);
      cmd(CMD_PARAM_RD, 3, 0, ST_SUCCESS);
      chk("readWord", 255, readWord);
      cmd(CMD_DEFAULTS, 0, 0, ST_SUCCESS);
      foreach (okCmd[k]) cmd(okCmd[k], 0, 0, ST_SUCCESS);
      cmd(CMD_REFILL, 0, 0, ST_SUCCESS);
      chk("refilling", 1, refilling);
      cmd(CMD_START_FILL, 0, 0, ST_BAD_STATE);
      @(posedge core_clk) sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      wt(2);
      chk("refilling", 0, refilling);
      cmd(CMD_START_FILL, 0, 0, ST_SUCCESS);
      chk("filling", 1, filling);
      cmd(CMD_REFILL, 0, 0, ST_BAD_STATE);
      @(posedge core_clk) fillDone <= 1'b1;
      @(posedge core_clk) fillDone <= 1'b0;
      @(posedge core_clk) sensorFound <= 1'b0;
      cmd(CMD_CAL_STORED, 0, 0, ST_NO_SENSOR);
      @(posedge core_clk) sensorFound <= 1'b1;
      capEqual <= 1'b0;
      cmd(CMD_CAL_STORED, 0, 0, ST_CAP_MISMAT);
      @(posedge core_clk) capEqual <= 1'b1;
      cmd(CMD_CAL_STORED, 0, 0, ST_SUCCESS);
      chk("calDone", 1, calDone);
      wt(8);
      chk("nvCal", 1, nvCal);
      @(posedge core_clk) spanCounts <= 24'h000009;
      cmd(CMD_CAL_LOW, 0, 0, ST_SUCCESS);
      cmd(CMD_CAL_HIGH, 0, 0, ST_SPAN_FAIL);
      @(posedge core_clk) spanCounts <= 24'h00000a;
      cmd(CMD_CAL_HIGH, 0, 0, ST_SUCCESS);
      end_of_test();
   end
endmodule
`default_nettype wire
